//--- logic/mgmt_mode_resume_logic.sv
// Management-mode entry and resume control
// Notes on behaviour
// (RULE1) Media, x87, fault-address, priority, breakpoint, range and model registers not saved.
// (RULE2) Halt-restart byte lives at save-area offset FEC9h.
// (RULE3) Entry writes halted flag in bit 0, zeros in bits 7:1.
// (RULE4) Resume: halt-restart zero continues saved state, non-zero returns to halt.
// (RULE5) Halt return does not re-execute halt; halt bus cycle follows resume.
// (RULE6) Port-restart byte lives at save-area offset FEC8h.
// (RULE7) Revision identifier bit 16 always reads one.
// (RULE8) Every management interrupt clears the port-restart byte before handler runs.
// (RULE9) Resume: port-restart zero skips instruction, non-zero re-executes it.
// (RULE10) Interrupted port instruction pointer, count, source, destination saved.
// (RULE11) Trap word: port 31:16, reserved 15:10 zero, flags in low bits.
// (RULE12) Address-width 32 and 16 flags sit at bits 8 and 7.
// (RULE13) Direction 0 output, 1 input; hit flag set when port instruction interrupted.
// (RULE14) Resume reloads state; outside management mode it raises undefined opcode.
// (RULE15) Invalid state on resume shuts down until reset, init or nonmaskable interrupt.
// (RULE16) Protection off with paging on, or cache on with no-write-through, invalid.
// (RULE17) High control/debug bits or unsupported page, control4, feature bits invalid.
// (RULE18) Long mode with paging needs address extension and not long-plus-default code.
// (RULE19) Modified saved revision identifier is invalid.
// (RULE20) Long-mode active becomes enable AND paging AND extension.
// (RULE21) Virtual-8086 flag ANDed with protection and inverse of long-mode active.
// (RULE22) Six system/extra bases sign-extended from highest implemented bit.
// (RULE23) Unimplemented base bits of code, data, extra, stack cleared.
// (RULE24) Handler writes non-zero halt restart only when entered from halt.
`timescale 1ns/1ps
module mgmt_mode_resume_logic #(
  parameter int virt_addr_bits = 48,
  parameter int seg_addr_bits = 32,
  parameter logic [31:0] mgmt_revision = mgmt_mode_pkg::mgmt_revision_default
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mgmt_interrupt,
  input wire logic core_halted,
  input wire logic port_instr_active,
  input wire mgmt_mode_pkg::port_access_s port_access,
  input wire logic [63:0] port_instr_pointer,
  input wire logic [63:0] port_count_reg,
  input wire logic [63:0] port_source_index,
  input wire logic [63:0] port_dest_index,
  input wire logic mgmt_resume,
  input wire logic ext_init,
  input wire logic nonmaskable_interrupt,
  input wire logic save_wr,
  input wire logic [15:0] save_addr,
  input wire logic [7:0] save_wdata,
  output logic [7:0] save_rdata,
  input wire mgmt_mode_pkg::saved_ctrl_s saved_ctrl,
  input wire mgmt_mode_pkg::seg_bases_s saved_bases,
  output logic in_mgmt_mode,
  output logic in_shutdown,
  output logic undefined_opcode_fault,
  output logic resume_done,
  output logic resume_to_halt,
  output logic halt_bus_cycle,
  output logic restart_port_instr,
  output logic [31:0] port_trap_info_word,
  output logic [63:0] trap_instr_pointer,
  output logic [63:0] trap_count_reg,
  output logic [63:0] trap_source_index,
  output logic [63:0] trap_dest_index,
  output logic [31:0] mgmt_revision_id,
  output logic long_mode_active,
  output logic virtual_8086_flag,
  output mgmt_mode_pkg::seg_bases_s restored_bases
);
  // ******************************
  // Core state and save-area fields
  // ******************************
  mgmt_mode_pkg::core_state_e state, next_state;
  logic [7:0] halt_restart_select, next_halt_restart_select;
  logic [7:0] port_restart_select, next_port_restart_select;
  logic [31:0] next_port_trap_info_word;
  logic [63:0] next_trap_instr_pointer, next_trap_count_reg;
  logic [63:0] next_trap_source_index, next_trap_dest_index;
  logic next_undefined_opcode_fault, next_resume_done, next_resume_to_halt;
  logic next_halt_bus_cycle, next_restart_port_instr;
  logic next_long_mode_active, next_virtual_8086_flag;
  mgmt_mode_pkg::seg_bases_s next_restored_bases;
  logic chk_invalid, chk_lm_act, chk_v86;
  mgmt_mode_pkg::seg_bases_s chk_bases;
  logic [31:0] trap_word;

  // Saved registers outside these fields are left to handler software [RULE1]
  saved_state_check #(
    .virt_addr_bits(virt_addr_bits),
    .seg_addr_bits(seg_addr_bits)
  ) u_check (
    .saved(saved_ctrl),
    .bases_in(saved_bases),
    .revision_at_entry(mgmt_revision_id),
    .invalid(chk_invalid),
    .long_mode_active(chk_lm_act),
    .virtual_8086_flag(chk_v86),
    .bases_out(chk_bases)
  );

  assign mgmt_revision_id = mgmt_revision
    | (32'h1 << mgmt_mode_pkg::rev_port_restart_bit); // [RULE7]
  assign in_mgmt_mode = (state == mgmt_mode_pkg::st_mgmt);
  assign in_shutdown = (state == mgmt_mode_pkg::st_shutdown);

  // ******************************
  // Trap word assembly
  // ******************************
  always_comb begin
    trap_word = 32'h0000_0000; // [RULE11]
    trap_word[31:mgmt_mode_pkg::trap_port_lsb] = port_access.port; // [RULE11]
    trap_word[mgmt_mode_pkg::trap_aw64_bit] = port_access.aw64; // [RULE11]
    trap_word[mgmt_mode_pkg::trap_aw32_bit] = port_access.aw32; // [RULE12]
    trap_word[mgmt_mode_pkg::trap_aw16_bit] = port_access.aw16; // [RULE12]
    trap_word[mgmt_mode_pkg::trap_pw32_bit] = port_access.pw32; // [RULE11]
    trap_word[mgmt_mode_pkg::trap_pw16_bit] = port_access.pw16; // [RULE11]
    trap_word[mgmt_mode_pkg::trap_pw8_bit] = port_access.pw8; // [RULE11]
    trap_word[mgmt_mode_pkg::trap_multi_bit] = port_access.multi; // [RULE11]
    trap_word[mgmt_mode_pkg::trap_block_bit] = port_access.block; // [RULE11]
    trap_word[mgmt_mode_pkg::trap_hit_bit] = 1'b1; // [RULE13]
    trap_word[mgmt_mode_pkg::trap_dir_bit] = port_access.is_input; // [RULE13]
  end

  // ******************************
  // Save-area byte reads
  // ******************************
  always_comb begin
    case (save_addr)
      mgmt_mode_pkg::port_restart_offset: save_rdata = port_restart_select; // [RULE6]
      mgmt_mode_pkg::halt_restart_offset: save_rdata = halt_restart_select; // [RULE2]
      default: save_rdata = 8'h00;
    endcase
  end

  // ******************************
  // Next-state logic
  // ******************************
  always_comb begin
    next_state = state;
    next_halt_restart_select = halt_restart_select;
    next_port_restart_select = port_restart_select;
    next_port_trap_info_word = port_trap_info_word;
    next_trap_instr_pointer = trap_instr_pointer;
    next_trap_count_reg = trap_count_reg;
    next_trap_source_index = trap_source_index;
    next_trap_dest_index = trap_dest_index;
    next_undefined_opcode_fault = 1'b0;
    next_resume_done = 1'b0;
    next_resume_to_halt = 1'b0;
    next_halt_bus_cycle = resume_to_halt; // [RULE5]
    next_restart_port_instr = 1'b0;
    next_long_mode_active = long_mode_active;
    next_virtual_8086_flag = virtual_8086_flag;
    next_restored_bases = restored_bases;
    case (state)
      mgmt_mode_pkg::st_normal: begin
        if (mgmt_interrupt) begin
          next_state = mgmt_mode_pkg::st_mgmt;
          next_halt_restart_select = {7'h00, core_halted}; // [RULE3]
          next_port_restart_select = mgmt_mode_pkg::port_restart_reset; // [RULE8]
          if (port_instr_active) begin
            next_port_trap_info_word = trap_word; // [RULE13]
            next_trap_instr_pointer = port_instr_pointer; // [RULE10]
            next_trap_count_reg = port_count_reg; // [RULE10]
            next_trap_source_index = port_source_index; // [RULE10]
            next_trap_dest_index = port_dest_index; // [RULE10]
          end else begin
            next_port_trap_info_word = 32'h0000_0000;
          end
        end else if (mgmt_resume) begin
          next_undefined_opcode_fault = 1'b1; // [RULE14]
        end
      end
      mgmt_mode_pkg::st_mgmt: begin
        if (save_wr && save_addr == mgmt_mode_pkg::halt_restart_offset) begin
          next_halt_restart_select = save_wdata; // [RULE2]
        end
        if (save_wr && save_addr == mgmt_mode_pkg::port_restart_offset) begin
          next_port_restart_select = save_wdata; // [RULE6]
        end
        if (mgmt_resume) begin
          if (chk_invalid) begin
            next_state = mgmt_mode_pkg::st_shutdown; // [RULE15]
          end else begin
            next_state = mgmt_mode_pkg::st_normal; // [RULE14]
            next_resume_done = 1'b1;
            next_resume_to_halt = (halt_restart_select != 8'h00); // [RULE4] [RULE24]
            next_restart_port_instr = (port_restart_select != 8'h00); // [RULE9]
            next_long_mode_active = chk_lm_act; // [RULE20]
            next_virtual_8086_flag = chk_v86; // [RULE21]
            next_restored_bases = chk_bases; // [RULE22] [RULE23]
          end
        end
      end
      mgmt_mode_pkg::st_shutdown: begin
        if (ext_init || nonmaskable_interrupt) begin
          next_state = mgmt_mode_pkg::st_normal; // [RULE15]
        end
      end
      default: next_state = mgmt_mode_pkg::st_normal;
    endcase
  end

  // ******************************
  // State registers
  // ******************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= mgmt_mode_pkg::st_normal;
      halt_restart_select <= mgmt_mode_pkg::halt_restart_reset;
      port_restart_select <= mgmt_mode_pkg::port_restart_reset;
      port_trap_info_word <= 32'h0000_0000;
      trap_instr_pointer <= 64'h0;
      trap_count_reg <= 64'h0;
      trap_source_index <= 64'h0;
      trap_dest_index <= 64'h0;
      undefined_opcode_fault <= 1'b0;
      resume_done <= 1'b0;
      resume_to_halt <= 1'b0;
      halt_bus_cycle <= 1'b0;
      restart_port_instr <= 1'b0;
      long_mode_active <= 1'b0;
      virtual_8086_flag <= 1'b0;
      restored_bases <= '0;
    end else begin
      state <= next_state;
      halt_restart_select <= next_halt_restart_select;
      port_restart_select <= next_port_restart_select;
      port_trap_info_word <= next_port_trap_info_word;
      trap_instr_pointer <= next_trap_instr_pointer;
      trap_count_reg <= next_trap_count_reg;
      trap_source_index <= next_trap_source_index;
      trap_dest_index <= next_trap_dest_index;
      undefined_opcode_fault <= next_undefined_opcode_fault;
      resume_done <= next_resume_done;
      resume_to_halt <= next_resume_to_halt;
      halt_bus_cycle <= next_halt_bus_cycle;
      restart_port_instr <= next_restart_port_instr;
      long_mode_active <= next_long_mode_active;
      virtual_8086_flag <= next_virtual_8086_flag;
      restored_bases <= next_restored_bases;
    end
  end
endmodule : mgmt_mode_resume_logic

//--- include/mgmt_mode_pkg.sv
// Package for the management-mode entry and resume logic
package mgmt_mode_pkg;
  // ******************************
  // State-save area offsets
  // ******************************
  localparam logic [15:0] port_restart_offset = 16'hfec8;
  localparam logic [15:0] halt_restart_offset = 16'hfec9;
  localparam logic [7:0] port_restart_reset = 8'h00;
  localparam logic [7:0] halt_restart_reset = 8'h00;
  // ******************************
  // Port-trap word field positions
  // ******************************
  localparam int trap_port_lsb = 16;
  localparam int trap_aw64_bit = 9;
  localparam int trap_aw32_bit = 8;
  localparam int trap_aw16_bit = 7;
  localparam int trap_pw32_bit = 6;
  localparam int trap_pw16_bit = 5;
  localparam int trap_pw8_bit = 4;
  localparam int trap_multi_bit = 3;
  localparam int trap_block_bit = 2;
  localparam int trap_hit_bit = 1;
  localparam int trap_dir_bit = 0;
  // ******************************
  // Revision identifier
  // ******************************
  localparam int rev_port_restart_bit = 16;
  // Arbitrary neutral revision value
  localparam logic [31:0] mgmt_revision_default = 32'h0001_0001;

  typedef enum logic [1:0] {
    st_normal = 2'b00,
    st_mgmt = 2'b01,
    st_shutdown = 2'b10
  } core_state_e;

  typedef struct packed {
    logic [15:0] port;
    logic aw64;
    logic aw32;
    logic aw16;
    logic pw32;
    logic pw16;
    logic pw8;
    logic multi;
    logic block;
    logic is_input;
  } port_access_s;

  typedef struct packed {
    logic [63:0] ctrl0;
    logic [63:0] page_base;
    logic [63:0] ctrl4;
    logic [63:0] dbg_status;
    logic [63:0] dbg_control;
    logic [63:0] ext_feature;
    logic [31:0] revision;
    logic v86;
    logic cs_long;
    logic cs_default;
  } saved_ctrl_s;

  typedef struct packed {
    logic [63:0] fseg_base;
    logic [63:0] gseg_base;
    logic [63:0] gdt_base;
    logic [63:0] idt_base;
    logic [63:0] ldt_base;
    logic [63:0] tss_base;
    logic [63:0] cs_base;
    logic [63:0] dseg_base;
    logic [63:0] eseg_base;
    logic [63:0] ss_base;
  } seg_bases_s;

  localparam int prot_bit = 0;
  localparam int nowt_bit = 29;
  localparam int cdis_bit = 30;
  localparam int pgen_bit = 31;
  localparam int paex_bit = 5;
  localparam int lmen_bit = 8;
endpackage : mgmt_mode_pkg

//--- logic/saved_state_check.sv
// Validity check and default fixups of the saved state on resume
`timescale 1ns/1ps
module saved_state_check #(
  parameter int virt_addr_bits = 48,
  parameter int seg_addr_bits = 32,
  parameter logic [63:0] page_base_ok = 64'h000f_ffff_ffff_ffff,
  parameter logic [63:0] ctrl4_ok = 64'h0000_0000_003f_ffff,
  parameter logic [63:0] ext_feature_ok = 64'h0000_0000_0000_0d01
) (
  input wire mgmt_mode_pkg::saved_ctrl_s saved,
  input wire mgmt_mode_pkg::seg_bases_s bases_in,
  input wire logic [31:0] revision_at_entry,
  output logic invalid,
  output logic long_mode_active,
  output logic virtual_8086_flag,
  output mgmt_mode_pkg::seg_bases_s bases_out
);
  if (virt_addr_bits < 32 || virt_addr_bits > 64 || seg_addr_bits < 20 || seg_addr_bits > 64)
  begin : bad_widths
    $error("saved_state_check: unsupported address widths");
  end

  function automatic logic [63:0] canon(input logic [63:0] b);
    logic [63:0] r;
    r = b;
    for (int i = 0; i < 64; i++) begin
      if (i >= virt_addr_bits) r[i] = b[virt_addr_bits - 1];
    end
    return r;
  endfunction : canon

  function automatic logic [63:0] trim(input logic [63:0] b);
    logic [63:0] r;
    r = b;
    for (int i = 0; i < 64; i++) begin
      if (i >= seg_addr_bits) r[i] = 1'b0;
    end
    return r;
  endfunction : trim

  logic prot, pgen, cdis, nowt, paex, lmen;

  always_comb begin
    prot = saved.ctrl0[mgmt_mode_pkg::prot_bit];
    pgen = saved.ctrl0[mgmt_mode_pkg::pgen_bit];
    cdis = saved.ctrl0[mgmt_mode_pkg::cdis_bit];
    nowt = saved.ctrl0[mgmt_mode_pkg::nowt_bit];
    paex = saved.ctrl4[mgmt_mode_pkg::paex_bit];
    lmen = saved.ext_feature[mgmt_mode_pkg::lmen_bit];
    invalid = (!prot && pgen) || (!cdis && nowt) // [RULE16]
      || (|saved.ctrl0[63:32]) || (|saved.dbg_status[63:32]) // [RULE17]
      || (|saved.dbg_control[63:32]) || (|(saved.page_base & ~page_base_ok)) // [RULE17]
      || (|(saved.ctrl4 & ~ctrl4_ok)) || (|(saved.ext_feature & ~ext_feature_ok)) // [RULE17]
      || (lmen && pgen && (!paex || (saved.cs_long && saved.cs_default))) // [RULE18]
      || (saved.revision != revision_at_entry); // [RULE19]
    long_mode_active = lmen & pgen & paex; // [RULE20]
    virtual_8086_flag = saved.v86 & prot & ~long_mode_active; // [RULE21]
    bases_out.fseg_base = canon(bases_in.fseg_base); // [RULE22]
    bases_out.gseg_base = canon(bases_in.gseg_base); // [RULE22]
    bases_out.gdt_base = canon(bases_in.gdt_base); // [RULE22]
    bases_out.idt_base = canon(bases_in.idt_base); // [RULE22]
    bases_out.ldt_base = canon(bases_in.ldt_base); // [RULE22]
    bases_out.tss_base = canon(bases_in.tss_base); // [RULE22]
    bases_out.cs_base = trim(bases_in.cs_base); // [RULE23]
    bases_out.dseg_base = trim(bases_in.dseg_base); // [RULE23]
    bases_out.eseg_base = trim(bases_in.eseg_base); // [RULE23]
    bases_out.ss_base = trim(bases_in.ss_base); // [RULE23]
  end
endmodule : saved_state_check

//--- testbench/mgmt_mode_checker.sv
// Assertions on the ports of the management-mode entry and resume logic
`timescale 1ns/1ps
module mgmt_mode_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mgmt_interrupt,
  input wire logic port_instr_active,
  input wire mgmt_mode_pkg::port_access_s port_access,
  input wire logic [63:0] port_instr_pointer,
  input wire logic mgmt_resume,
  input wire logic ext_init,
  input wire logic nonmaskable_interrupt,
  input wire mgmt_mode_pkg::saved_ctrl_s saved_ctrl,
  input wire logic in_mgmt_mode,
  input wire logic in_shutdown,
  input wire logic undefined_opcode_fault,
  input wire logic resume_done,
  input wire logic resume_to_halt,
  input wire logic halt_bus_cycle,
  input wire logic [31:0] port_trap_info_word,
  input wire logic [63:0] trap_instr_pointer,
  input wire logic [31:0] mgmt_revision_id,
  input wire logic long_mode_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic idle;
  assign idle = !in_mgmt_mode && !in_shutdown;
  trap_word_a: assert property (idle && mgmt_interrupt && port_instr_active |=>
    port_trap_info_word == {$past(port_access[24:9]), 6'h00, $past(port_access[8:1]), 1'h1,
    $past(port_access[0])}) else $error("trap word layout wrong");
  trap_none_a: assert property (idle && mgmt_interrupt && !port_instr_active |=>
    port_trap_info_word == 32'h0) else $error("trap word not clear without port access");
  trap_ptr_a: assert property (idle && mgmt_interrupt && port_instr_active |=>
    trap_instr_pointer == $past(port_instr_pointer)) else $error("trap pointer not captured");
  rev_bit_a: assert property (mgmt_revision_id[16]) else $error("revision bit 16 low");
  undef_op_a: assert property (idle && mgmt_resume && !mgmt_interrupt |=>
    undefined_opcode_fault && !resume_done ##1 !undefined_opcode_fault)
    else $error("resume outside mode not faulted");
  halt_bus_a: assert property (resume_to_halt |-> resume_done ##1 halt_bus_cycle)
    else $error("halt bus cycle missing after halt return");
  lmode_calc_a: assert property (resume_done |-> long_mode_active ==
    ($past(saved_ctrl.ext_feature[8]) && $past(saved_ctrl.ctrl0[31]) &&
    $past(saved_ctrl.ctrl4[5]))) else $error("long mode active wrong");
  bad_state_a: assert property (in_mgmt_mode && mgmt_resume && saved_ctrl.ctrl0[31] &&
    !saved_ctrl.ctrl0[0] |=> in_shutdown && !resume_done) else $error("no shutdown");
  shut_hold_a: assert property (in_shutdown && !ext_init && !nonmaskable_interrupt
    |=> in_shutdown) else $error("shutdown left without release");
endmodule : mgmt_mode_checker

//--- testbench/mgmt_system_model.sv
// Model of the system logic and handler software around the block
`timescale 1ns/1ps
module mgmt_system_model (
  input wire logic clk,
  output logic mgmt_interrupt,
  output logic core_halted,
  output logic port_instr_active,
  output mgmt_mode_pkg::port_access_s port_access,
  output logic [63:0] port_instr_pointer,
  output logic [63:0] port_count_reg,
  output logic [63:0] port_source_index,
  output logic [63:0] port_dest_index,
  output logic mgmt_resume,
  output logic save_wr,
  output logic [15:0] save_addr,
  output logic [7:0] save_wdata,
  input wire logic [7:0] save_rdata
);
  logic from_halt;
  initial begin
    {mgmt_interrupt, core_halted, port_instr_active, mgmt_resume, save_wr, from_halt} = '0;
    port_access = '0;
    {port_instr_pointer, port_count_reg, port_source_index, port_dest_index} = '0;
    save_addr = 16'h0000;
    save_wdata = 8'h00;
  end
  task enter(input logic halted, input logic active, input mgmt_mode_pkg::port_access_s acc,
             input logic [63:0] ip);
    @(posedge clk);
    #1;
    {mgmt_interrupt, core_halted, port_instr_active, from_halt} = {1'h1, halted, active, halted};
    port_access = acc;
    port_instr_pointer = ip;
    port_count_reg = ip + 64'h1;
    port_source_index = ip + 64'h2;
    port_dest_index = ip + 64'h3;
    @(posedge clk);
    #1;
    mgmt_interrupt = 1'h0;
    port_access = ~acc;
    port_instr_pointer = ~ip;
  endtask : enter
  task write_byte(input logic [15:0] addr, input logic [7:0] data);
    if (addr == 16'hfec9 && !from_halt) data = 8'h00;
    @(posedge clk);
    #1;
    {save_wr, save_addr, save_wdata} = {1'h1, addr, data};
    @(posedge clk);
    #1;
    save_wr = 1'h0;
    save_wdata = ~data;
  endtask : write_byte
  task read_byte(input logic [15:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1;
    save_addr = addr;
    #1;
    data = save_rdata;
  endtask : read_byte
  task resume();
    @(posedge clk);
    #1;
    mgmt_resume = 1'h1;
    @(posedge clk);
    #1;
    mgmt_resume = 1'h0;
  endtask : resume
endmodule : mgmt_system_model

//--- testbench/mgmt_mode_resume_logic_tb.sv
// Self-checking bench for the management-mode entry and resume logic
`timescale 1ns/1ps
module mgmt_mode_resume_logic_tb;
  logic clk, sys_rst, ext_init, nonmaskable_interrupt, mgmt_interrupt, core_halted;
  logic port_instr_active, mgmt_resume, save_wr, in_mgmt_mode, in_shutdown;
  logic undefined_opcode_fault, resume_done, resume_to_halt, halt_bus_cycle, restart_port_instr;
  logic long_mode_active, virtual_8086_flag;
  logic [7:0] save_wdata, save_rdata, b;
  logic [15:0] save_addr;
  logic [31:0] port_trap_info_word, mgmt_revision_id;
  logic [63:0] port_instr_pointer, port_count_reg, port_source_index, port_dest_index;
  logic [63:0] trap_instr_pointer, trap_count_reg, trap_source_index, trap_dest_index;
  mgmt_mode_pkg::port_access_s port_access;
  mgmt_mode_pkg::saved_ctrl_s sc;
  mgmt_mode_pkg::seg_bases_s sb, restored_bases;
  int n_fail, total_checks, cycles;
  mgmt_mode_resume_logic DUT (.clk(clk), .sys_rst(sys_rst), .mgmt_interrupt(mgmt_interrupt),
    .core_halted(core_halted), .port_instr_active(port_instr_active),
    .port_access(port_access), .port_instr_pointer(port_instr_pointer),
    .port_count_reg(port_count_reg), .port_source_index(port_source_index),
    .port_dest_index(port_dest_index), .mgmt_resume(mgmt_resume), .ext_init(ext_init),
    .nonmaskable_interrupt(nonmaskable_interrupt), .save_wr(save_wr), .save_addr(save_addr),
    .save_wdata(save_wdata), .save_rdata(save_rdata), .saved_ctrl(sc), .saved_bases(sb),
    .in_mgmt_mode(in_mgmt_mode), .in_shutdown(in_shutdown),
    .undefined_opcode_fault(undefined_opcode_fault), .resume_done(resume_done),
    .resume_to_halt(resume_to_halt), .halt_bus_cycle(halt_bus_cycle),
    .restart_port_instr(restart_port_instr), .port_trap_info_word(port_trap_info_word),
    .trap_instr_pointer(trap_instr_pointer), .trap_count_reg(trap_count_reg),
    .trap_source_index(trap_source_index), .trap_dest_index(trap_dest_index),
    .mgmt_revision_id(mgmt_revision_id), .long_mode_active(long_mode_active),
    .virtual_8086_flag(virtual_8086_flag), .restored_bases(restored_bases));
  mgmt_system_model sys (.clk(clk), .mgmt_interrupt(mgmt_interrupt), .core_halted(core_halted),
    .port_instr_active(port_instr_active), .port_access(port_access),
    .port_instr_pointer(port_instr_pointer), .port_count_reg(port_count_reg),
    .port_source_index(port_source_index), .port_dest_index(port_dest_index),
    .mgmt_resume(mgmt_resume), .save_wr(save_wr), .save_addr(save_addr),
    .save_wdata(save_wdata), .save_rdata(save_rdata));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      results();
    end
  end
  task check(input string name, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : check
  task results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task set_long();
    sc = '0;
    sc.revision = mgmt_mode_pkg::mgmt_revision_default;
    sc.ctrl0 = 64'h0000_0000_8000_0001;
    sc.ctrl4 = 64'h0000_0000_0000_0020;
    sc.ext_feature = 64'h0000_0000_0000_0100;
    sc.v86 = 1'h1;
  endtask : set_long
  task t_halt_port();
    sys.enter(1'h1, 1'h1, {16'h0cf8, 9'h1a5}, 64'h1000);
    check("in_mgmt", 1'h1, in_mgmt_mode);
    sys.read_byte(16'hfec9, b);
    check("halt_byte", 8'h01, b);
    sys.read_byte(16'hfec8, b);
    check("port_byte", 8'h00, b);
    check("trap_word", 32'h0cf8_034b, port_trap_info_word);
    check("trap_ip", 64'h1000, trap_instr_pointer);
    check("trap_cnt", 64'h1001, trap_count_reg);
    check("trap_src", 64'h1002, trap_source_index);
    check("trap_dst", 64'h1003, trap_dest_index);
    sys.write_byte(16'hfec8, 8'h01);
    set_long();
    sb = '0;
    sb.fseg_base = 64'h0000_8000_0000_0000;
    sb.gdt_base = 64'h0001_0000_0000_0000;
    sb.cs_base = 64'h0000_0001_0000_1234;
    sys.resume();
    check("done", 1'h1, resume_done);
    check("to_halt", 1'h1, resume_to_halt);
    check("restart", 1'h1, restart_port_instr);
    check("lma", 1'h1, long_mode_active);
    check("v86", 1'h0, virtual_8086_flag);
    check("fs", 64'hffff_8000_0000_0000, restored_bases.fseg_base);
    check("gdt", 64'h0, restored_bases.gdt_base);
    check("cs", 64'h1234, restored_bases.cs_base);
    @(posedge clk);
    #1;
    check("halt_bus", 1'h1, halt_bus_cycle);
    $display("test halt_port done");
  endtask : t_halt_port
  task t_plain();
    sys.enter(1'h0, 1'h0, '0, 64'h2000);
    check("trap_word", 32'h0, port_trap_info_word);
    sys.read_byte(16'hfec9, b);
    check("halt_byte", 8'h00, b);
    sys.read_byte(16'hfec8, b);
    check("port_byte", 8'h00, b);
    sys.write_byte(16'hfec9, 8'h01);
    sys.write_byte(16'hfeca, 8'h55);
    sys.read_byte(16'hfeca, b);
    check("unmapped", 8'h00, b);
    sc = '0;
    sc.revision = mgmt_mode_pkg::mgmt_revision_default;
    sc.ctrl0 = 64'h1;
    sc.v86 = 1'h1;
    sys.resume();
    check("to_halt", 1'h0, resume_to_halt);
    check("restart", 1'h0, restart_port_instr);
    check("v86", 1'h1, virtual_8086_flag);
    sys.resume();
    check("ud", 1'h1, undefined_opcode_fault);
    check("ud_done", 1'h0, resume_done);
    check("rev", 1'h1, mgmt_revision_id[16]);
    $display("test plain done");
  endtask : t_plain
  task t_invalid();
    for (int i = 0; i < 11; i++) begin
      set_long();
      case (i)
        0: sc.ctrl0[0] = 1'h0;
        1: sc.ctrl0[29] = 1'h1;
        2: sc.ctrl0[40] = 1'h1;
        3: sc.dbg_status[33] = 1'h1;
        4: sc.dbg_control[63] = 1'h1;
        5: sc.page_base[63] = 1'h1;
        6: sc.ctrl4[40] = 1'h1;
        7: sc.ext_feature[1] = 1'h1;
        8: sc.ctrl4[5] = 1'h0;
        9: {sc.cs_long, sc.cs_default} = 2'h3;
        default: sc.revision = sc.revision ^ 32'h1;
      endcase
      sys.enter(1'h0, 1'h0, '0, 64'h3000);
      sys.resume();
      check("shutdown", 1'h1, in_shutdown);
      sys.resume();
      check("shut_ud", 1'h0, undefined_opcode_fault);
      case (i % 3)
        0: ext_init = 1'h1;
        1: nonmaskable_interrupt = 1'h1;
        default: sys_rst = 1'h1;
      endcase
      @(posedge clk);
      #1;
      {ext_init, nonmaskable_interrupt, sys_rst} = 3'h0;
      check("released", 1'h0, in_shutdown);
    end
    $display("test invalid done");
  endtask : t_invalid
  initial begin
    {sys_rst, ext_init, nonmaskable_interrupt} = 3'h4;
    {n_fail, total_checks, cycles} = '0;
    sc = '0;
    sb = '0;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    t_halt_port();
    t_plain();
    t_invalid();
    results();
  end
endmodule : mgmt_mode_resume_logic_tb
bind mgmt_mode_resume_logic mgmt_mode_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .mgmt_interrupt(mgmt_interrupt), .port_instr_active(port_instr_active),
  .port_access(port_access), .port_instr_pointer(port_instr_pointer),
  .mgmt_resume(mgmt_resume), .ext_init(ext_init), .nonmaskable_interrupt(nonmaskable_interrupt),
  .saved_ctrl(saved_ctrl), .in_mgmt_mode(in_mgmt_mode), .in_shutdown(in_shutdown),
  .undefined_opcode_fault(undefined_opcode_fault), .resume_done(resume_done),
  .resume_to_halt(resume_to_halt), .halt_bus_cycle(halt_bus_cycle),
  .port_trap_info_word(port_trap_info_word), .trap_instr_pointer(trap_instr_pointer),
  .mgmt_revision_id(mgmt_revision_id), .long_mode_active(long_mode_active));
